// [rtl/lcdd_decoder.v]
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "lcdd_defs.vh"
// What this block does
// - Clear fills character RAM with spaces, zeroes counter, homes cursor, sets increment.
// - Return home zeroes counter and undoes display shift, RAM kept.
// - RAM access steps counter up when incr_direction high, down when low.
// - Data access shifts display only on character RAM write with shift-on-write enabled.
// - Panel on, cursor on and cursor blink bits are held.
// - Cursor shift steps counter by direction; display shift leaves counter alone.
// - Two-line cursor wraps from line one end onto line two; shift hits all lines.
// - bus_width_sel selects 8-bit bus or 4-bit bus of two nibbles.
// - line_count_sel picks lines; tall font in one line with instr_set_pin low limits addresses to 27H.
// - table_select chooses extension or normal instruction table.
// - Glyph address set loads 6-bit counter and targets glyph RAM.
// - Character address ranges follow one-line or two-line mode.
// - Status read gives busy flag and counter; busy refuses new instructions.
// - Data accesses target the RAM chosen by the last address set.
// - Counter steps by one after each data write.
// - First read without prior address set returns a stale byte.
// - bias_select picks quarter or fifth bias unless external resistors used.
// - osc_trim adjusts the oscillator only when clock_source_sel is high.
// - Symbol address set loads 4-bit address in extension table.
// - Power command sets symbol layer, and pump and top contrast bits under internal follower.
// - Follower command sets amplifier enable and ratio under internal follower.
// - Contrast assembled from two plus four bits, internal follower only.
// - Extension table usable only when instr_set_pin is low.
// - Busy lasts 26.3 us normally and 1.08 ms for clear and home.
module lcdd_decoder #(
  parameter BUSY_INSTR = (`LCDD_T_INSTR_NS * `LCDD_CLK_MHZ + `LCDD_NS_PER_US - 1)
                         / `LCDD_NS_PER_US,
  parameter BUSY_HOME  = (`LCDD_T_HOME_NS * `LCDD_CLK_MHZ + `LCDD_NS_PER_US - 1)
                         / `LCDD_NS_PER_US
) (
  // Clock and reset.
  input  wire        pclk,
  input  wire        presetn,
  // APB slave.
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Host instruction bus.
  input  wire        host_strobe,
  input  wire        reg_select,
  input  wire        host_read,
  input  wire [7:0]  host_db_in,
  output reg  [7:0]  host_db_out,
  output reg         host_db_oe,
  // Display state.
  output reg         busy_flag,
  output reg  [6:0]  addr_counter,
  output reg         panel_on,
  output reg         cursor_on,
  output reg         cursor_blink_on,
  output reg  [5:0]  shift_offset,
  output reg         two_line_mode,
  output reg         tall_font_mode,
  // Analog configuration.
  output reg         bias_quarter,
  output reg  [2:0]  osc_trim_eff,
  output reg         symbol_layer_on,
  output reg         pump_enable,
  output reg         buffer_amp_enable,
  output reg  [2:0]  amp_ratio,
  output reg  [5:0]  contrast_level
);

  // ==========================================================================
  // State.
  reg [7:0]  char_ram [0:127];
  reg [7:0]  glyph_ram [0:63];
  reg [7:0]  symbol_ram [0:15];
  reg [3:0]  cfg;
  reg [`LCDD_BUSY_W-1:0] busy_cnt;
  reg [1:0]  target;
  reg        incr_direction;
  reg        display_shift_on_write;
  reg        bus_width_sel;
  reg        line_count_sel;
  reg        tall_font_sel;
  reg        table_select;
  reg        bias_select;
  reg [2:0]  osc_trim;
  reg        nib_second;
  reg [3:0]  nib_hold;
  reg [7:0]  rd_latch;
  reg        refill;
  reg        clr_active;
  reg [6:0]  clr_idx;
  reg [7:0]  instr_reg;
  reg        wr_go;
  reg [6:0]  wr_addr;
  reg [1:0]  wr_tgt;

  wire       instr_set_pin    = cfg[`LCDD_CFG_ISP];
  wire       clock_source_sel = cfg[`LCDD_CFG_CLS];
  wire       bias_source_sel  = cfg[`LCDD_CFG_BSA];
  wire       bias_source_sel_b = cfg[`LCDD_CFG_BSB];
  wire       int_follower = ~bias_source_sel & ~bias_source_sel_b;
  wire       ext_resistor = bias_source_sel & bias_source_sel_b;
  wire       tall_eff = tall_font_sel & ~line_count_sel & ~instr_set_pin;
  wire       ext_table = table_select & ~instr_set_pin;

  // ==========================================================================
  // Host byte assembly.
  wire       status_rd = ~reg_select & host_read;
  wire       take = host_strobe & (status_rd | ~busy_flag);
  wire       byte_done = take & (bus_width_sel | nib_second);
  wire [7:0] host_byte = bus_width_sel ? host_db_in : {nib_hold, host_db_in[7:4]};
  wire [7:0] rd_value = status_rd ? {busy_flag, addr_counter} : rd_latch;

  // ==========================================================================
  // Counter stepping and RAM read.
  function [6:0] lcdd_step;
    input [6:0] a;
    input       up;
    input [1:0] t;
    input       two;
    input       tall;
    reg   [6:0] lim;
    begin
      lim = tall ? `LCDD_L1_END : `LCDD_ONE_END;
      if (t == `LCDD_TGT_GLYPH) begin
        lcdd_step = (up ? a + `LCDD_A_ONE : a - `LCDD_A_ONE) & `LCDD_GLYPH_MASK;
      end else if (t == `LCDD_TGT_SYM) begin
        lcdd_step = (up ? a + `LCDD_A_ONE : a - `LCDD_A_ONE) & `LCDD_SYM_MASK;
      end else if (two) begin
        if (up) begin
          lcdd_step = (a == `LCDD_L1_END) ? `LCDD_L2_BEG :
                      (a == `LCDD_L2_END) ? `LCDD_A_ZERO : a + `LCDD_A_ONE;
        end else begin
          lcdd_step = (a == `LCDD_L2_BEG) ? `LCDD_L1_END :
                      (a == `LCDD_A_ZERO) ? `LCDD_L2_END : a - `LCDD_A_ONE;
        end
      end else if (up) begin
        lcdd_step = (a == lim) ? `LCDD_A_ZERO : a + `LCDD_A_ONE;
      end else begin
        lcdd_step = (a == `LCDD_A_ZERO) ? lim : a - `LCDD_A_ONE;
      end
    end
  endfunction

  function [5:0] lcdd_shift;
    input [5:0] s;
    input       left;
    begin
      if (left) begin
        lcdd_shift = (s == `LCDD_SH_LAST) ? 6'h00 : s + `LCDD_SH_ONE;
      end else begin
        lcdd_shift = (s == 6'h00) ? `LCDD_SH_LAST : s - `LCDD_SH_ONE;
      end
    end
  endfunction

  wire [6:0] ac_next = lcdd_step(addr_counter, incr_direction, target,
                                 line_count_sel, tall_eff);
  wire [7:0] ram_rd = (target == `LCDD_TGT_GLYPH) ? glyph_ram[addr_counter[5:0]] :
                      (target == `LCDD_TGT_SYM) ? symbol_ram[addr_counter[3:0]] :
                      char_ram[addr_counter];

  // ==========================================================================
  // RAM writes.
  always @(posedge pclk) begin
    if (clr_active) begin
      char_ram[clr_idx] <= `LCDD_SPACE;
    end else if (wr_go && wr_tgt == `LCDD_TGT_CHAR) begin
      char_ram[wr_addr] <= instr_reg;
    end
    if (wr_go && wr_tgt == `LCDD_TGT_GLYPH) begin
      glyph_ram[wr_addr[5:0]] <= instr_reg;
    end
    if (wr_go && wr_tgt == `LCDD_TGT_SYM) begin
      symbol_ram[wr_addr[3:0]] <= instr_reg;
    end
  end

  // ==========================================================================
  // APB slave.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg     <= `LCDD_CFG_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && penable && pready && pwrite && paddr == `LCDD_A_CFG) begin
        cfg <= pwdata[3:0];
      end
      if (psel && penable && !pready) begin
        case (paddr)
          `LCDD_A_CFG: begin
            prdata <= {28'h0000000, cfg};
          end
          `LCDD_A_STATUS: begin
            prdata <= {14'h0000, shift_offset, target, incr_direction, nib_second,
                       busy_flag, addr_counter};
          end
          `LCDD_A_SETUP: begin
            prdata <= {8'h00, contrast_level, amp_ratio, buffer_amp_enable, pump_enable,
                       symbol_layer_on, osc_trim, bias_select, table_select,
                       tall_font_sel, line_count_sel, bus_width_sel,
                       display_shift_on_write, cursor_blink_on, cursor_on, panel_on};
          end
          default: begin
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Instruction interpreter.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt <= {`LCDD_BUSY_W{1'b0}};
      busy_flag <= 1'b0;
      addr_counter <= `LCDD_A_ZERO;
      target <= `LCDD_TGT_CHAR;
      incr_direction <= 1'b1;
      display_shift_on_write <= 1'b0;
      panel_on <= 1'b0;
      cursor_on <= 1'b0;
      cursor_blink_on <= 1'b0;
      shift_offset <= 6'h00;
      bus_width_sel <= 1'b1;
      line_count_sel <= 1'b0;
      tall_font_sel <= 1'b0;
      table_select <= 1'b0;
      bias_select <= 1'b0;
      osc_trim <= 3'h0;
      symbol_layer_on <= 1'b0;
      pump_enable <= 1'b0;
      buffer_amp_enable <= 1'b0;
      amp_ratio <= 3'h0;
      contrast_level <= `LCDD_CONTRAST_RST;
      nib_second <= 1'b0;
      nib_hold <= 4'h0;
      rd_latch <= 8'h00;
      refill <= 1'b0;
      clr_active <= 1'b0;
      clr_idx <= `LCDD_A_ZERO;
      instr_reg <= 8'h00;
      wr_go <= 1'b0;
      wr_addr <= `LCDD_A_ZERO;
      wr_tgt <= `LCDD_TGT_CHAR;
      host_db_out <= 8'h00;
      host_db_oe <= 1'b0;
      two_line_mode <= 1'b0;
      tall_font_mode <= 1'b0;
      bias_quarter <= 1'b0;
      osc_trim_eff <= 3'h0;
    end else begin
      wr_go <= 1'b0;
      refill <= 1'b0;
      two_line_mode <= line_count_sel;
      tall_font_mode <= tall_eff;
      bias_quarter <= bias_select & ~ext_resistor;
      osc_trim_eff <= clock_source_sel ? osc_trim : 3'h0;
      if (refill) begin
        rd_latch <= ram_rd;
      end
      if (clr_active) begin
        clr_idx <= clr_idx + `LCDD_A_ONE;
        clr_active <= (clr_idx != `LCDD_CHAR_LAST);
      end
      if (busy_cnt != {`LCDD_BUSY_W{1'b0}}) begin
        busy_cnt <= busy_cnt - 1'b1;
        busy_flag <= (busy_cnt != {{(`LCDD_BUSY_W-1){1'b0}}, 1'b1});
      end
      if (take) begin
        if (!bus_width_sel && !nib_second) begin
          nib_second <= 1'b1;
          nib_hold <= host_db_in[7:4];
          if (host_read) begin
            host_db_out <= {rd_value[7:4], 4'h0};
            nib_hold <= rd_value[3:0];
          end
        end else begin
          nib_second <= 1'b0;
          if (host_read) begin
            host_db_out <= bus_width_sel ? rd_value : {nib_hold, 4'h0};
          end
        end
        host_db_oe <= host_read;
      end
      if (byte_done && !status_rd) begin
        busy_flag <= 1'b1;
        busy_cnt <= BUSY_INSTR[`LCDD_BUSY_W-1:0];
        instr_reg <= host_byte;
        if (reg_select && !host_read) begin
          wr_go <= 1'b1;
          wr_addr <= addr_counter;
          wr_tgt <= target;
          addr_counter <= ac_next;
          if (display_shift_on_write && target == `LCDD_TGT_CHAR) begin
            shift_offset <= lcdd_shift(shift_offset, incr_direction);
          end
        end else if (reg_select) begin
          addr_counter <= ac_next;
          refill <= 1'b1;
        end else begin
          casez (host_byte)
            `LCDD_OP_CLEAR: begin
              clr_active <= 1'b1;
              clr_idx <= `LCDD_A_ZERO;
              addr_counter <= `LCDD_A_ZERO;
              target <= `LCDD_TGT_CHAR;
              shift_offset <= 6'h00;
              incr_direction <= 1'b1;
              busy_cnt <= BUSY_HOME[`LCDD_BUSY_W-1:0];
            end
            `LCDD_OP_HOME: begin
              addr_counter <= `LCDD_A_ZERO;
              target <= `LCDD_TGT_CHAR;
              shift_offset <= 6'h00;
              busy_cnt <= BUSY_HOME[`LCDD_BUSY_W-1:0];
            end
            `LCDD_OP_EMODE: begin
              incr_direction <= host_byte[1];
              display_shift_on_write <= host_byte[0];
            end
            `LCDD_OP_DISP: begin
              panel_on <= host_byte[2];
              cursor_on <= host_byte[1];
              cursor_blink_on <= host_byte[0];
            end
            `LCDD_OP_SHOSC: begin
              if (ext_table) begin
                bias_select <= host_byte[3];
                osc_trim <= host_byte[2:0];
              end else if (host_byte[3]) begin
                shift_offset <= lcdd_shift(shift_offset, ~host_byte[2]);
              end else begin
                addr_counter <= lcdd_step(addr_counter, host_byte[2], target,
                                          line_count_sel, tall_eff);
              end
            end
            `LCDD_OP_FSET: begin
              bus_width_sel <= host_byte[4];
              line_count_sel <= host_byte[3];
              tall_font_sel <= host_byte[2];
              table_select <= host_byte[0] & ~instr_set_pin;
            end
            `LCDD_OP_CHAR: begin
              addr_counter <= host_byte[6:0];
              target <= `LCDD_TGT_CHAR;
              refill <= 1'b1;
            end
            default: begin
              if (!ext_table) begin
                addr_counter <= {1'b0, host_byte[5:0]};
                target <= `LCDD_TGT_GLYPH;
                refill <= 1'b1;
              end else begin
                casez (host_byte)
                  `LCDD_OP_SYM: begin
                    addr_counter <= {3'h0, host_byte[3:0]};
                    target <= `LCDD_TGT_SYM;
                    refill <= 1'b1;
                  end
                  `LCDD_OP_PWR: begin
                    symbol_layer_on <= host_byte[3];
                    if (int_follower) begin
                      pump_enable <= host_byte[2];
                      contrast_level[5:4] <= host_byte[1:0];
                    end
                  end
                  `LCDD_OP_FOL: begin
                    if (int_follower) begin
                      buffer_amp_enable <= host_byte[3];
                      amp_ratio <= host_byte[2:0];
                    end
                  end
                  `LCDD_OP_CON: begin
                    if (int_follower) begin
                      contrast_level[3:0] <= host_byte[3:0];
                    end
                  end
                  default: begin
                    refill <= 1'b0;
                  end
                endcase
              end
            end
          endcase
        end
      end
    end
  end

endmodule

// [rtl/lcdd_defs.vh]
`ifndef LCDD_DEFS_VH
`define LCDD_DEFS_VH
// ==========================================================================
// Timing.
`define LCDD_CLK_MHZ     200
`define LCDD_NS_PER_US   1000
`define LCDD_T_INSTR_NS  26300
`define LCDD_T_HOME_NS   1080000
`define LCDD_BUSY_W      18
// ==========================================================================
// Register map and fields.
`define LCDD_A_CFG       12'h000
`define LCDD_A_STATUS    12'h004
`define LCDD_A_SETUP     12'h008
`define LCDD_CFG_RST     4'h0
`define LCDD_CFG_ISP     0
`define LCDD_CFG_CLS     1
`define LCDD_CFG_BSA     2
`define LCDD_CFG_BSB     3
// ==========================================================================
// Data targets and address limits.
`define LCDD_TGT_CHAR    2'h0
`define LCDD_TGT_GLYPH   2'h1
`define LCDD_TGT_SYM     2'h2
`define LCDD_SPACE       8'h20
`define LCDD_A_ZERO      7'h00
`define LCDD_A_ONE       7'h01
`define LCDD_L1_END      7'h27
`define LCDD_L2_BEG      7'h40
`define LCDD_L2_END      7'h67
`define LCDD_ONE_END     7'h4F
`define LCDD_CHAR_LAST   7'h7F
`define LCDD_GLYPH_MASK  7'h3F
`define LCDD_SYM_MASK    7'h0F
`define LCDD_SH_ONE      6'h01
`define LCDD_SH_LAST     6'h27
`define LCDD_CONTRAST_RST 6'h00
// ==========================================================================
// Instruction patterns.
`define LCDD_OP_CLEAR    8'b00000001
`define LCDD_OP_HOME     8'b0000001?
`define LCDD_OP_EMODE    8'b000001??
`define LCDD_OP_DISP     8'b00001???
`define LCDD_OP_SHOSC    8'b0001????
`define LCDD_OP_FSET     8'b001?????
`define LCDD_OP_SYM      8'b0100????
`define LCDD_OP_PWR      8'b0101????
`define LCDD_OP_FOL      8'b0110????
`define LCDD_OP_CON      8'b0111????
`define LCDD_OP_CHAR     8'b1???????
`endif

// [sim/lcdd_host.sv]
`timescale 1ns/1ps
// ==========================================================================
// Host processor model driving the instruction bus.
module lcdd_host (
  // Clock.
  input  wire       pclk,
  // Device side.
  input  wire       busy_flag,
  input  wire [7:0] host_db_out,
  // Host bus.
  output reg        host_strobe,
  output reg        reg_select,
  output reg        host_read,
  output reg  [7:0] host_db_in
);
  reg     nib;
  integer stuck;
  initial begin
    host_strobe = 1'b0;
    reg_select  = 1'b0;
    host_read   = 1'b0;
    host_db_in  = 8'h00;
    nib         = 1'b0;
    stuck       = 0;
  end
  // One strobed transfer; released data lines carry the inverse afterwards.
  task pulse(input r, input w, input [7:0] d);
    begin
      @(posedge pclk);
      host_strobe <= 1'b1;
      reg_select  <= r;
      host_read   <= w;
      host_db_in  <= d;
      @(posedge pclk);
      host_strobe <= 1'b0;
      host_db_in  <= ~d;
    end
  endtask
  // One byte; status reads skip the busy wait.
  task xfer(input r, input w, input [7:0] d, output [7:0] q);
    integer n;
    begin
      n = 0;
      while (!(w && !r) && busy_flag !== 1'b0 && n < 300) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 300) stuck = stuck + 1;
      if (nib) begin
        pulse(r, w, {d[7:4], 4'h0});
        @(negedge pclk);
        q[7:4] = host_db_out[7:4];
        pulse(r, w, {d[3:0], 4'h0});
      end else begin
        pulse(r, w, d);
      end
      @(negedge pclk);
      q = nib ? {q[7:4], host_db_out[7:4]} : host_db_out;
    end
  endtask
endmodule

// [sim/lcdd_properties.sv]
`timescale 1ns/1ps
// ==========================================================================
// Checker for the host instruction bus.
module lcdd_properties #(
  parameter BUSY_INSTR = 20,
  parameter BUSY_HOME  = 200
) (
  // Clock and reset.
  input wire       pclk,
  input wire       presetn,
  // Host bus.
  input wire       host_strobe,
  input wire       reg_select,
  input wire       host_read,
  input wire [7:0] host_db_in,
  input wire [7:0] host_db_out,
  input wire       host_db_oe,
  // Display state.
  input wire       busy_flag,
  input wire [6:0] addr_counter,
  input wire       panel_on,
  input wire       cursor_on,
  input wire       cursor_blink_on,
  input wire [5:0] shift_offset
);
  reg        wide;
  reg        incr;
  reg [7:0]  last_db;
  reg [31:0] bcnt;
  wire       acc = host_strobe && !busy_flag && wide;
  wire       ins = acc && !reg_select && !host_read;
  // ========================================================================
  // Tracking of bus width, entry direction and busy length.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide    <= 1'b1;
      incr    <= 1'b1;
      last_db <= 8'h00;
      bcnt    <= 32'h0;
    end else begin
      last_db <= host_db_in;
      bcnt    <= busy_flag ? bcnt + 32'h1 : 32'h0;
      if (ins && host_db_in[7:5] == 3'h1) wide <= host_db_in[4];
      if (ins && host_db_in[7:2] == 6'h01) incr <= host_db_in[1];
      else if (ins && host_db_in == 8'h01) incr <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ========================================================================
  // Assertions.
  property p_refuse;
    busy_flag && host_strobe && reg_select |=> $stable(host_db_oe) && $stable(host_db_out);
  endproperty
  a_refuse: assert property (p_refuse) else $error("data access taken while busy");
  property p_status;
    host_strobe && wide && !reg_select && host_read
      |=> host_db_oe && host_db_out == {$past(busy_flag), $past(addr_counter)};
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");
  property p_clear;
    ins && host_db_in == 8'h01 |=> addr_counter == 7'h00 && busy_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left counter set");
  property p_home;
    ins && host_db_in[7:1] == 7'h01 |=> addr_counter == 7'h00 && shift_offset == 6'h00;
  endproperty
  a_home: assert property (p_home) else $error("home left counter or shift");
  property p_ddset;
    ins && host_db_in[7] && host_db_in[6:0] <= 7'h27 |=> addr_counter == last_db[6:0];
  endproperty
  a_ddset: assert property (p_ddset) else $error("address set not loaded");
  property p_disp;
    ins && host_db_in[7:3] == 5'h01 |=> {panel_on, cursor_on, cursor_blink_on} == last_db[2:0];
  endproperty
  a_disp: assert property (p_disp) else $error("display control bits wrong");
  property p_shkeep;
    ins && host_db_in[7:3] == 5'h03 |=> $stable(addr_counter);
  endproperty
  a_shkeep: assert property (p_shkeep) else $error("display shift moved counter");
  property p_wstep;
    acc && reg_select && addr_counter >= 7'h01 && addr_counter <= 7'h0E
      |=> addr_counter == (incr ? $past(addr_counter) + 7'h01 : $past(addr_counter) - 7'h01);
  endproperty
  a_wstep: assert property (p_wstep) else $error("counter step wrong");
  property p_busy;
    $fell(busy_flag) |-> bcnt == BUSY_INSTR || bcnt == BUSY_HOME;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length wrong");
endmodule

// [sim/test_char_lcd_instruction_decoder.sv]
`timescale 1ns/1ps
// ==========================================================================
// Self-checking bench for the instruction decoder.
module test_char_lcd_instruction_decoder;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, host_strobe, reg_select, host_read, host_db_oe, busy_flag;
  wire [7:0]  host_db_in, host_db_out;
  wire [6:0]  addr_counter;
  wire        panel_on, cursor_on, cursor_blink_on, two_line_mode, tall_font_mode;
  wire [5:0]  shift_offset, contrast_level;
  wire        bias_quarter, symbol_layer_on, pump_enable, buffer_amp_enable;
  wire [2:0]  osc_trim_eff, amp_ratio;
  reg  [7:0]  q;
  reg  [31:0] prd;
  reg         perr;
  integer     i, miscompares = 0, checked = 0;
  reg  [15:0] rows [0:10] = '{16'h0100, 16'h0600, 16'h8505, 16'h4186, 16'h1005, 16'h1406,
                              16'h0406, 16'h4285, 16'h0200, 16'h4A0A, 16'h5589};
  always #2.5 pclk = ~pclk;
  lcdd_decoder #(.BUSY_INSTR(20), .BUSY_HOME(200)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_strobe(host_strobe), .reg_select(reg_select), .host_read(host_read),
    .host_db_in(host_db_in), .host_db_out(host_db_out), .host_db_oe(host_db_oe),
    .busy_flag(busy_flag), .addr_counter(addr_counter), .panel_on(panel_on),
    .cursor_on(cursor_on), .cursor_blink_on(cursor_blink_on), .shift_offset(shift_offset),
    .two_line_mode(two_line_mode), .tall_font_mode(tall_font_mode),
    .bias_quarter(bias_quarter), .osc_trim_eff(osc_trim_eff), .symbol_layer_on(symbol_layer_on),
    .pump_enable(pump_enable), .buffer_amp_enable(buffer_amp_enable), .amp_ratio(amp_ratio),
    .contrast_level(contrast_level));
  lcdd_host host_u (.pclk(pclk), .busy_flag(busy_flag), .host_db_out(host_db_out),
    .host_strobe(host_strobe), .reg_select(reg_select), .host_read(host_read),
    .host_db_in(host_db_in));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      miscompares = miscompares + host_u.stuck;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 50);
      prd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
        miscompares = miscompares + 1;
        results();
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'({busy_flag, addr_counter, host_db_oe, shift_offset}), 0);
    for (i = 0; i < 11; i = i + 1) begin
      host_u.xfer(rows[i][7], 1'b0, rows[i][15:8], q);
      check(32'(addr_counter), 32'(rows[i][6:0]));
    end
    host_u.xfer(1'b0, 1'b0, 8'h85, q);
    host_u.xfer(1'b1, 1'b1, 8'h00, q);
    check(32'(q), 32'h41);
    check(32'(addr_counter), 32'h04);
    host_u.xfer(1'b1, 1'b1, 8'h00, q);
    check(32'(q), 32'h20);
    host_u.xfer(1'b0, 1'b0, 8'h07, q);
    host_u.xfer(1'b1, 1'b0, 8'h43, q);
    check(32'(shift_offset), 32'h1);
    host_u.xfer(1'b1, 1'b1, 8'h00, q);
    check(32'(shift_offset), 32'h1);
    host_u.xfer(1'b0, 1'b0, 8'h02, q);
    check(32'(shift_offset), 32'h0);
    host_u.xfer(1'b0, 1'b0, 8'h0F, q);
    check(32'({panel_on, cursor_on, cursor_blink_on}), 32'h7);
    host_u.xfer(1'b0, 1'b0, 8'h0A, q);
    check(32'({panel_on, cursor_on, cursor_blink_on}), 32'h2);
    host_u.xfer(1'b0, 1'b0, 8'h80, q);
    host_u.pulse(1'b1, 1'b0, 8'h8A);
    host_u.xfer(1'b0, 1'b1, 8'h00, q);
    check(32'(q), 32'h80);
    host_u.xfer(1'b0, 1'b0, 8'h39, q);
    @(negedge pclk);
    check(32'(two_line_mode), 32'h1);
    host_u.xfer(1'b0, 1'b0, 8'h1D, q);
    @(negedge pclk);
    check(32'({bias_quarter, osc_trim_eff}), 32'h8);
    apb(1'b1, 12'h000, 32'h2);
    host_u.xfer(1'b0, 1'b0, 8'h5E, q);
    host_u.xfer(1'b0, 1'b0, 8'h6D, q);
    host_u.xfer(1'b0, 1'b0, 8'h7A, q);
    host_u.xfer(1'b0, 1'b0, 8'h43, q);
    check(32'({osc_trim_eff, symbol_layer_on, pump_enable, buffer_amp_enable, amp_ratio,
               contrast_level, addr_counter}), 32'({3'h5, 3'h7, 3'h5, 6'h2A, 7'h03}));
    apb(1'b1, 12'h000, 32'hE);
    host_u.xfer(1'b0, 1'b0, 8'h7F, q);
    host_u.xfer(1'b0, 1'b0, 8'h60, q);
    host_u.xfer(1'b0, 1'b0, 8'h58, q);
    check(32'({bias_quarter, pump_enable, buffer_amp_enable, amp_ratio, contrast_level}),
          32'({3'h3, 3'h5, 6'h2A}));
    apb(1'b0, 12'h000, 32'h0);
    check(prd, 32'hE);
    apb(1'b1, 12'h004, 32'hFFFF);
    apb(1'b0, 12'h004, 32'h0);
    check(32'({prd[11:8], prd[6:0]}), 32'({4'hA, 7'h03}));
    apb(1'b0, 12'h00C, 32'h0);
    check({prd[30:0], perr}, 32'h1);
    host_u.xfer(1'b0, 1'b0, 8'h28, q);
    host_u.nib = 1'b1;
    host_u.xfer(1'b0, 1'b0, 8'h92, q);
    check(32'(addr_counter), 32'h12);
    host_u.xfer(1'b1, 1'b0, 8'h55, q);
    host_u.xfer(1'b0, 1'b1, 8'h00, q);
    check(32'(q), 32'h93);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(32'({busy_flag, addr_counter, shift_offset, panel_on}), 0);
    results();
  end
endmodule
bind lcdd_decoder lcdd_properties #(.BUSY_INSTR(BUSY_INSTR), .BUSY_HOME(BUSY_HOME)) chk_u (
  .pclk(pclk), .presetn(presetn), .host_strobe(host_strobe), .reg_select(reg_select),
  .host_read(host_read), .host_db_in(host_db_in), .host_db_out(host_db_out),
  .host_db_oe(host_db_oe), .busy_flag(busy_flag), .addr_counter(addr_counter),
  .panel_on(panel_on), .cursor_on(cursor_on), .cursor_blink_on(cursor_blink_on),
  .shift_offset(shift_offset));
